// ==== hw/power_mode_clock_control.sv ====
// power_mode_clock_control: power-mode sequencing and system clock control.
// assumes oscillator ticks are one-cycle enables on clk_sys, reset_n is the
// merged reset of every reset source, and wake inputs may be asynchronous.
//
// Overview of operation
// - idle stops core clock only, interrupt wakes
// - suspend gates clocks, stops fast oscillators, normal bias
// - snooze as suspend with low regulator bias
// - timers 3/4 run; listed events wake suspend
// - stop powers down nets, any reset exits
// - shutdown with stop-config, only pin/POR exit
// - reset gives 24.5 MHz source divided by 8
// - divider offers 1 to 128 in powers two
// - both fast oscillators offer 1.5x pre-scale
// - unused peripheral clocks are gated off
// - sources are 24.5M, 49M, 80k, external
`timescale 1ns/1ps
`default_nettype none

module power_mode_clock_control (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rd_data,
    input wire logic hf_osc_24m_tick,
    input wire logic hf_osc_49m_tick,
    input wire logic low_freq_osc_tick,
    input wire logic external_clock_source_tick,
    input wire logic any_interrupt,
    input wire logic timer4_event,
    input wire logic spi_activity,
    input wire logic i2c_slave_activity,
    input wire logic port_match,
    input wire logic comparator0_level,
    input wire logic [3:0] logic_unit_n_irq,
    output logic core_clk_en,
    output logic [7:0] periph_clk_en,
    output logic timer34_lf_clk_en,
    output logic hf_osc_24m_enable,
    output logic hf_osc_49m_enable,
    output logic [1:0] external_clock_kind,
    output logic regulator_low_bias,
    output logic power_nets_off,
    output logic pin_retain,
    output logic reset_pin_por_only
);

    power_clock_pkg::power_mode_type mode_reg;
    power_clock_pkg::power_mode_type mode_next;
    logic idle_req_reg, idle_req_next;
    logic stop_req_reg, stop_req_next;
    logic suspend_req_reg, suspend_req_next;
    logic snooze_req_reg, snooze_req_next;
    logic stop_config_reg, stop_config_next;
    logic [1:0] source_reg, source_next;
    logic [1:0] ext_kind_reg, ext_kind_next;
    logic [2:0] divider_reg, divider_next;
    logic [1:0] prescale_reg, prescale_next;
    logic [7:0] periph_en_reg, periph_en_next;
    logic [3:0] wake_en_reg, wake_en_next;
    logic [7:0] rd_data_reg, rd_data_next;
    logic [7:0] osc_cnt_reg, osc_cnt_next;
    logic [8:0] sync1_reg;
    logic [8:0] sync2_reg;
    logic cmp0_prev_reg;
    logic core_en_reg, core_en_next;
    logic [7:0] periph_clk_reg, periph_clk_next;
    logic lf_en_reg, lf_en_next;
    logic src_tick;
    logic src_prescale;
    logic scaled_tick;
    logic wake_event;
    logic cmp0_fall;
    logic low_power;

    localparam logic [7:0] OSC_START = 8'(power_clock_pkg::OSC_START_CYCLES);

    // register offset hit for a strobe
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
        hit = (addr == off);
    endfunction

    // wake inputs cross from other clocks, two flops before use
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync1_reg <= 9'h000;
            sync2_reg <= 9'h000;
            cmp0_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= {comparator0_level, logic_unit_n_irq, port_match, i2c_slave_activity,
                          spi_activity, timer4_event};
            sync2_reg <= sync1_reg;
            cmp0_prev_reg <= sync2_reg[8];
        end
    end

    assign cmp0_fall = cmp0_prev_reg && !sync2_reg[8];
    assign wake_event = (|sync2_reg[3:0]) || cmp0_fall || (|(sync2_reg[7:4] & wake_en_reg));

    // source selection among the four clock sources
    always_comb begin
        src_tick = hf_osc_24m_tick;
        src_prescale = prescale_reg[power_clock_pkg::BIT_PRE_24M];
        case (source_reg)
            power_clock_pkg::SRC_HF_OSC_49M: begin
                src_tick = hf_osc_49m_tick;
                src_prescale = prescale_reg[power_clock_pkg::BIT_PRE_49M];
            end
            power_clock_pkg::SRC_LOW_FREQ_OSC: begin
                src_tick = low_freq_osc_tick;
                src_prescale = 1'b0;
            end
            power_clock_pkg::SRC_EXTERNAL: begin
                src_tick = external_clock_source_tick;
                src_prescale = 1'b0;
            end
            default: begin
                src_tick = hf_osc_24m_tick;
            end
        endcase
    end

    clock_scaler scaler (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .src_tick(src_tick),
        .prescale_en(src_prescale),
        .div_sel(divider_reg),
        .tick_out(scaled_tick)
    );

    // mode sequencing and register writes
    always_comb begin
        mode_next = mode_reg;
        idle_req_next = idle_req_reg;
        stop_req_next = stop_req_reg;
        suspend_req_next = suspend_req_reg;
        snooze_req_next = snooze_req_reg;
        osc_cnt_next = osc_cnt_reg;
        case (mode_reg)
            power_clock_pkg::MODE_NORMAL: begin
                if (stop_req_reg && stop_config_reg) begin
                    mode_next = power_clock_pkg::MODE_SHUTDOWN;
                end else if (stop_req_reg) begin
                    mode_next = power_clock_pkg::MODE_STOP;
                end else if (suspend_req_reg) begin
                    mode_next = power_clock_pkg::MODE_SUSPEND;
                end else if (snooze_req_reg) begin
                    mode_next = power_clock_pkg::MODE_SNOOZE;
                end else if (idle_req_reg) begin
                    mode_next = power_clock_pkg::MODE_IDLE;
                end
            end
            power_clock_pkg::MODE_IDLE: begin
                if (any_interrupt) begin
                    idle_req_next = 1'b0;
                    mode_next = power_clock_pkg::MODE_NORMAL;
                end
            end
            power_clock_pkg::MODE_SUSPEND, power_clock_pkg::MODE_SNOOZE: begin
                if (wake_event) begin
                    suspend_req_next = 1'b0;
                    snooze_req_next = 1'b0;
                    osc_cnt_next = OSC_START;
                    mode_next = power_clock_pkg::MODE_WAKE;
                end
            end
            power_clock_pkg::MODE_WAKE: begin
                // oscillator settles before the core clock returns
                if (osc_cnt_reg <= 8'h01) begin
                    osc_cnt_next = 8'h00;
                    mode_next = power_clock_pkg::MODE_NORMAL;
                end else begin
                    osc_cnt_next = osc_cnt_reg - 8'h01;
                end
            end
            default: begin
                // stop and shutdown are left only through reset
                mode_next = mode_reg;
            end
        endcase
        // a write in the same cycle wins over the hardware clear
        if (reg_wr && hit(reg_addr, power_clock_pkg::OFF_POWER_CONTROL_FIRST)) begin
            idle_req_next = reg_wr_data[power_clock_pkg::BIT_IDLE];
            stop_req_next = reg_wr_data[power_clock_pkg::BIT_STOP];
        end
        if (reg_wr && hit(reg_addr, power_clock_pkg::OFF_POWER_CONTROL_SECOND)) begin
            suspend_req_next = reg_wr_data[power_clock_pkg::BIT_SUSPEND];
            snooze_req_next = reg_wr_data[power_clock_pkg::BIT_SNOOZE];
        end
    end

    // configuration registers and read port
    always_comb begin
        stop_config_next = stop_config_reg;
        source_next = source_reg;
        ext_kind_next = ext_kind_reg;
        divider_next = divider_reg;
        prescale_next = prescale_reg;
        periph_en_next = periph_en_reg;
        wake_en_next = wake_en_reg;
        rd_data_next = 8'h00;
        if (reg_wr) begin
            if (hit(reg_addr, power_clock_pkg::OFF_REGULATOR_CONTROL)) begin
                stop_config_next = reg_wr_data[power_clock_pkg::BIT_STOP_CONFIG];
            end else if (hit(reg_addr, power_clock_pkg::OFF_CLOCK_SELECT)) begin
                source_next = reg_wr_data[power_clock_pkg::POS_SOURCE +: 2];
                ext_kind_next = reg_wr_data[power_clock_pkg::POS_EXT_KIND +: 2];
                divider_next = reg_wr_data[power_clock_pkg::POS_DIVIDER +: 3];
            end else if (hit(reg_addr, power_clock_pkg::OFF_PRESCALE)) begin
                prescale_next = reg_wr_data[1:0];
            end else if (hit(reg_addr, power_clock_pkg::OFF_PERIPH_CLOCK_ENABLE)) begin
                periph_en_next = reg_wr_data;
            end else if (hit(reg_addr, power_clock_pkg::OFF_WAKE_ENABLE)) begin
                wake_en_next = reg_wr_data[3:0];
            end
        end
        if (reg_rd) begin
            if (hit(reg_addr, power_clock_pkg::OFF_POWER_CONTROL_FIRST)) begin
                rd_data_next = {6'h00, stop_req_reg, idle_req_reg};
            end else if (hit(reg_addr, power_clock_pkg::OFF_POWER_CONTROL_SECOND)) begin
                rd_data_next = {6'h00, snooze_req_reg, suspend_req_reg};
            end else if (hit(reg_addr, power_clock_pkg::OFF_REGULATOR_CONTROL)) begin
                rd_data_next = {7'h00, stop_config_reg};
            end else if (hit(reg_addr, power_clock_pkg::OFF_CLOCK_SELECT)) begin
                rd_data_next = {1'b0, divider_reg, ext_kind_reg, source_reg};
            end else if (hit(reg_addr, power_clock_pkg::OFF_PRESCALE)) begin
                rd_data_next = {6'h00, prescale_reg};
            end else if (hit(reg_addr, power_clock_pkg::OFF_PERIPH_CLOCK_ENABLE)) begin
                rd_data_next = periph_en_reg;
            end else if (hit(reg_addr, power_clock_pkg::OFF_WAKE_ENABLE)) begin
                rd_data_next = {4'h0, wake_en_reg};
            end else if (hit(reg_addr, power_clock_pkg::OFF_STATUS)) begin
                rd_data_next = {1'b0, regulator_low_bias, hf_osc_49m_enable, hf_osc_24m_enable,
                                1'b0, mode_reg};
            end
        end
    end

    assign low_power = (mode_reg == power_clock_pkg::MODE_SUSPEND) ||
                       (mode_reg == power_clock_pkg::MODE_SNOOZE);

    // clock enable pulses per mode
    always_comb begin
        core_en_next = 1'b0;
        periph_clk_next = 8'h00;
        lf_en_next = 1'b0;
        if (mode_reg == power_clock_pkg::MODE_NORMAL) begin
            core_en_next = scaled_tick;
            periph_clk_next = {8{scaled_tick}} & periph_en_reg;
        end else if (mode_reg == power_clock_pkg::MODE_IDLE) begin
            periph_clk_next = {8{scaled_tick}} & periph_en_reg;
        end
        if (low_power) begin
            lf_en_next = low_freq_osc_tick;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode_reg <= power_clock_pkg::MODE_NORMAL;
            idle_req_reg <= 1'b0;
            stop_req_reg <= 1'b0;
            suspend_req_reg <= 1'b0;
            snooze_req_reg <= 1'b0;
            stop_config_reg <= 1'b0;
            source_reg <= power_clock_pkg::RESET_SOURCE;
            ext_kind_reg <= power_clock_pkg::EXT_RC;
            divider_reg <= power_clock_pkg::RESET_DIVIDER;
            prescale_reg <= 2'h0;
            periph_en_reg <= power_clock_pkg::RESET_PERIPH_CLOCK_ENABLE;
            wake_en_reg <= power_clock_pkg::RESET_WAKE_ENABLE;
            rd_data_reg <= 8'h00;
            osc_cnt_reg <= 8'h00;
            core_en_reg <= 1'b0;
            periph_clk_reg <= 8'h00;
            lf_en_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            idle_req_reg <= idle_req_next;
            stop_req_reg <= stop_req_next;
            suspend_req_reg <= suspend_req_next;
            snooze_req_reg <= snooze_req_next;
            stop_config_reg <= stop_config_next;
            source_reg <= source_next;
            ext_kind_reg <= ext_kind_next;
            divider_reg <= divider_next;
            prescale_reg <= prescale_next;
            periph_en_reg <= periph_en_next;
            wake_en_reg <= wake_en_next;
            rd_data_reg <= rd_data_next;
            osc_cnt_reg <= osc_cnt_next;
            core_en_reg <= core_en_next;
            periph_clk_reg <= periph_clk_next;
            lf_en_reg <= lf_en_next;
        end
    end

    assign reg_rd_data = rd_data_reg;
    assign core_clk_en = core_en_reg;
    assign periph_clk_en = periph_clk_reg;
    assign timer34_lf_clk_en = lf_en_reg;
    assign external_clock_kind = ext_kind_reg;
    // fast oscillators stop in suspend, snooze, stop and shutdown
    assign hf_osc_24m_enable = (mode_reg == power_clock_pkg::MODE_NORMAL) ||
                               (mode_reg == power_clock_pkg::MODE_IDLE) ||
                               (mode_reg == power_clock_pkg::MODE_WAKE);
    assign hf_osc_49m_enable = hf_osc_24m_enable && (source_reg == power_clock_pkg::SRC_HF_OSC_49M);
    assign regulator_low_bias = (mode_reg == power_clock_pkg::MODE_SNOOZE);
    assign power_nets_off = (mode_reg == power_clock_pkg::MODE_STOP) ||
                            (mode_reg == power_clock_pkg::MODE_SHUTDOWN);
    assign pin_retain = power_nets_off;
    assign reset_pin_por_only = (mode_reg == power_clock_pkg::MODE_SHUTDOWN);

endmodule

`default_nettype wire

// ==== hw/power_clock_pkg.sv ====
// power_clock_pkg: register map, field positions, reset values, encodings
// and timing counts for the power-mode and system-clock control block.
// assumes a 100 MHz controlling clock and an 8-bit register port.
package power_clock_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [3:0] OFF_POWER_CONTROL_FIRST = 4'h0;
    localparam logic [3:0] OFF_POWER_CONTROL_SECOND = 4'h1;
    localparam logic [3:0] OFF_REGULATOR_CONTROL = 4'h2;
    localparam logic [3:0] OFF_CLOCK_SELECT = 4'h3;
    localparam logic [3:0] OFF_PRESCALE = 4'h4;
    localparam logic [3:0] OFF_PERIPH_CLOCK_ENABLE = 4'h5;
    localparam logic [3:0] OFF_WAKE_ENABLE = 4'h6;
    localparam logic [3:0] OFF_STATUS = 4'h7;

    // power_control_first fields
    localparam int BIT_IDLE = 0;
    localparam int BIT_STOP = 1;
    // power_control_second fields
    localparam int BIT_SUSPEND = 0;
    localparam int BIT_SNOOZE = 1;
    // regulator_control fields
    localparam int BIT_STOP_CONFIG = 0;
    // clock_select fields
    localparam int POS_SOURCE = 0;
    localparam int POS_EXT_KIND = 2;
    localparam int POS_DIVIDER = 4;
    // prescale fields
    localparam int BIT_PRE_24M = 0;
    localparam int BIT_PRE_49M = 1;
    // status fields
    localparam int POS_MODE = 0;
    localparam int BIT_HF24_ON = 4;
    localparam int BIT_HF49_ON = 5;
    localparam int BIT_LOW_BIAS = 6;

    // clock source encodings
    localparam logic [1:0] SRC_HF_OSC_24M = 2'h0;
    localparam logic [1:0] SRC_HF_OSC_49M = 2'h1;
    localparam logic [1:0] SRC_LOW_FREQ_OSC = 2'h2;
    localparam logic [1:0] SRC_EXTERNAL = 2'h3;
    // external clock kinds
    localparam logic [1:0] EXT_RC = 2'h0;
    localparam logic [1:0] EXT_CMOS = 2'h1;
    localparam logic [1:0] EXT_CRYSTAL = 2'h2;

    // reset values: 24.5 MHz source, divide by 8
    localparam logic [1:0] RESET_SOURCE = SRC_HF_OSC_24M;
    localparam logic [2:0] RESET_DIVIDER = 3'h3;
    localparam logic [7:0] RESET_PERIPH_CLOCK_ENABLE = 8'h00;
    localparam logic [3:0] RESET_WAKE_ENABLE = 4'h0;

    // oscillator restart time before the core clock is ungated
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_START_NS = 2000;
    localparam int OSC_START_CYCLES = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_IDLE,
        MODE_SUSPEND,
        MODE_SNOOZE,
        MODE_STOP,
        MODE_SHUTDOWN,
        MODE_WAKE
    } power_mode_type;

endpackage

// ==== hw/clock_scaler.sv ====
// clock_scaler: turns a source tick into a scaled enable pulse, with an
// optional 1.5x pre-scaler ahead of a divide by 2^div_sel.
// assumes src_tick is a one-cycle enable on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module clock_scaler (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic src_tick,
    input wire logic prescale_en,
    input wire logic [2:0] div_sel,
    output logic tick_out
);

    logic [1:0] pre_reg;
    logic [1:0] pre_next;
    logic [6:0] div_reg;
    logic [6:0] div_next;
    logic tick_reg;
    logic tick_next;
    logic pre_tick;
    logic [6:0] div_limit;

    // 1.5x pre-scale: two of every three source ticks pass
    always_comb begin
        pre_next = pre_reg;
        pre_tick = src_tick;
        if (prescale_en && src_tick) begin
            pre_next = (pre_reg == 2'h2) ? 2'h0 : pre_reg + 2'h1;
            pre_tick = (pre_reg != 2'h2);
        end
    end

    assign div_limit = 7'((8'h01 << div_sel) - 8'h01);

    // divide by 1, 2, 4 ... 128
    always_comb begin
        div_next = div_reg;
        tick_next = 1'b0;
        if (pre_tick) begin
            if (div_reg >= div_limit) begin
                div_next = 7'h00;
                tick_next = 1'b1;
            end else begin
                div_next = div_reg + 7'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pre_reg <= 2'h0;
            div_reg <= 7'h00;
            tick_reg <= 1'b0;
        end else begin
            pre_reg <= pre_next;
            div_reg <= div_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_out = tick_reg;

endmodule

`default_nettype wire

// ==== verification/power_mode_clock_control_properties.sv ====
// checker: mode output checks.
// assumes a bind onto the design top.
`timescale 1ns/1ps
`default_nettype none

module power_mode_clock_control_properties (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic low_freq_osc_tick,
    input wire logic core_clk_en,
    input wire logic [7:0] periph_clk_en,
    input wire logic timer34_lf_clk_en,
    input wire logic hf_osc_24m_enable,
    input wire logic hf_osc_49m_enable,
    input wire logic regulator_low_bias,
    input wire logic power_nets_off,
    input wire logic pin_retain,
    input wire logic reset_pin_por_only
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    // oscillator off long enough for registered enables to follow
    sequence osc_off2;
        !hf_osc_24m_enable [*2];
    endsequence
    sequence sleep2;
        (!hf_osc_24m_enable && !power_nets_off) [*2];
    endsequence

    nets_hold_a: assert property (power_nets_off |=> power_nets_off && pin_retain)
        else $error("nets back without reset");
    shutdown_hold_a: assert property (reset_pin_por_only |=> reset_pin_por_only && power_nets_off)
        else $error("shutdown left early");
    shutdown_nets_a: assert property (reset_pin_por_only |-> pin_retain && !hf_osc_24m_enable)
        else $error("shutdown outputs wrong");
    bias_osc_off_a: assert property (regulator_low_bias |-> !hf_osc_24m_enable && !hf_osc_49m_enable)
        else $error("low bias, oscillator on");
    osc49_pair_a: assert property (hf_osc_49m_enable |-> hf_osc_24m_enable)
        else $error("49 MHz on, 24.5 MHz off");
    clocks_gated_a: assert property (osc_off2 |-> !core_clk_en && periph_clk_en == 8'h00)
        else $error("clock pulse while asleep");
    wake_restart_a: assert property ($rose(hf_osc_24m_enable) |-> !core_clk_en [*8])
        else $error("core clock before restart");
    timer_lf_src_a: assert property (timer34_lf_clk_en |-> $past(low_freq_osc_tick) && !core_clk_en)
        else $error("timer pulse without tick");
    timer_lf_pass_a: assert property (sleep2 ##0 $past(low_freq_osc_tick) |-> timer34_lf_clk_en)
        else $error("timer tick lost");
endmodule

`default_nettype wire

// ==== verification/power_mode_clock_control_bench.sv ====
// bench: register-port tests of power modes and clocks.
// assumes the checker file is compiled too.
`timescale 1ns/1ps
`default_nettype none

module power_mode_clock_control_bench;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wr_data = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rd_data;
    logic lf_tick = 1'b0;
    logic ext_tick = 1'b0;
    logic [1:0] phase = 2'h0;
    logic any_irq = 1'b0;
    logic [4:0] wk = 5'h00;
    logic [3:0] lu_irq = 4'h0;
    logic core_clk_en, timer34_lf_clk_en, hf24_en, hf49_en, low_bias, nets_off, retain, por_only;
    logic [7:0] periph_clk_en;
    logic [1:0] ext_kind;
    logic [1:0] kind;
    logic [7:0] cnt, seen, tcnt;
    logic [7:0] src_exp [4] = '{8'h80, 8'h60, 8'h20, 8'h40};
    int miscompares = 0;
    int checked = 0;

    power_mode_clock_control dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
        .hf_osc_24m_tick(1'b1), .hf_osc_49m_tick(~lf_tick), .low_freq_osc_tick(lf_tick),
        .external_clock_source_tick(ext_tick), .any_interrupt(any_irq), .timer4_event(wk[0]),
        .spi_activity(wk[1]), .i2c_slave_activity(wk[2]), .port_match(wk[3]),
        .comparator0_level(~wk[4]), .logic_unit_n_irq(lu_irq), .core_clk_en(core_clk_en),
        .periph_clk_en(periph_clk_en), .timer34_lf_clk_en(timer34_lf_clk_en),
        .hf_osc_24m_enable(hf24_en), .hf_osc_49m_enable(hf49_en), .external_clock_kind(ext_kind),
        .regulator_low_bias(low_bias), .power_nets_off(nets_off), .pin_retain(retain),
        .reset_pin_por_only(por_only)
    );

    always #5 clk_sys = ~clk_sys;

    // ticks: low-frequency 1 in 4, external 1 in 2
    always @(posedge clk_sys) begin
        phase <= phase + 2'h1;
        lf_tick <= (phase == 2'h3);
        ext_tick <= phase[0];
    end

    task automatic tally_and_finish();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        cyc(1);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        cyc(1);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
        cyc(1);
        reg_rd <= 1'b1;
        reg_addr <= a;
        cyc(1);
        reg_rd <= 1'b0;
        #1;
        chk8(name, exp, reg_rd_data);
    endtask

    task automatic count(input int n);
        cnt = 8'h00;
        seen = 8'h00;
        tcnt = 8'h00;
        repeat (n) begin
            @(negedge clk_sys);
            cnt += 8'(core_clk_en);
            tcnt += 8'(timer34_lf_clk_en);
            seen |= periph_clk_en;
        end
    endtask

    task automatic wait_core(input int bound);
        int k = 0;
        while (core_clk_en !== 1'b1 && k < bound) begin
            @(negedge clk_sys);
            k++;
        end
        if (k >= bound) begin
            miscompares++;
            $display("BAD core_wait expected 1 seen %b", core_clk_en);
            tally_and_finish();
        end
    endtask

    task automatic do_reset();
        cyc(1);
        reset_n <= 1'b0;
        cyc(12);
        reset_n <= 1'b1;
    endtask

    initial begin
        cyc(50000);
        miscompares++;
        $display("BAD run_length expected end seen hang");
        tally_and_finish();
    end

    initial begin
        do_reset();
        rd(power_clock_pkg::OFF_CLOCK_SELECT, 8'h30, "clock_select");
        rd(power_clock_pkg::OFF_STATUS, 8'h10, "status");
        count(64);
        chk8("core_pulses", 8'h08, cnt);
        chk8("periph_off", 8'h00, seen);
        done("reset");
        for (int d = 0; d < 8; d++) begin
            wr(power_clock_pkg::OFF_CLOCK_SELECT, 8'(d << 4));
            cyc(130);
            count(128);
            chk8("divider_pulses", 8'(128 >> d), cnt);
        end
        done("divider");
        for (int s = 0; s < 4; s++) begin
            kind = (s > 2) ? 2'h2 : 2'(s);
            wr(power_clock_pkg::OFF_CLOCK_SELECT, {4'h0, kind, 2'(s)});
            cyc(10);
            count(128);
            chk8("source_pulses", src_exp[s], cnt);
            chk8("ext_kind", {6'h0, kind}, {6'h0, ext_kind});
            chk8("osc49_enable", {7'h0, s == 1}, {7'h0, hf49_en});
        end
        for (int s = 0; s < 2; s++) begin
            wr(power_clock_pkg::OFF_CLOCK_SELECT, 8'(s));
            wr(power_clock_pkg::OFF_PRESCALE, 8'(1 << s));
            cyc(10);
            count(120);
            chk8("prescale_pulses", s ? 8'h3C : 8'h50, cnt);
        end
        wr(power_clock_pkg::OFF_PRESCALE, 8'h00);
        wr(power_clock_pkg::OFF_CLOCK_SELECT, 8'h00);
        done("sources");
        wr(power_clock_pkg::OFF_PERIPH_CLOCK_ENABLE, 8'h05);
        rd(power_clock_pkg::OFF_PERIPH_CLOCK_ENABLE, 8'h05, "periph_enable");
        wr(4'h8, 8'hFF);
        rd(4'h8, 8'h00, "unmapped");
        wr(power_clock_pkg::OFF_STATUS, 8'hFF);
        rd(power_clock_pkg::OFF_STATUS, 8'h10, "status_ro");
        wr(power_clock_pkg::OFF_POWER_CONTROL_FIRST, 8'h01);
        cyc(3);
        count(32);
        chk8("idle_core", 8'h00, cnt);
        chk8("idle_periph", 8'h05, seen);
        rd(power_clock_pkg::OFF_STATUS, 8'h11, "idle_status");
        cyc(1);
        any_irq <= 1'b1;
        cyc(1);
        any_irq <= 1'b0;
        cyc(3);
        rd(power_clock_pkg::OFF_POWER_CONTROL_FIRST, 8'h00, "idle_cleared");
        count(32);
        chk8("idle_woke", 8'h20, cnt);
        done("idle");
        wr(power_clock_pkg::OFF_WAKE_ENABLE, 8'h01);
        for (int i = 0; i < 6; i++) begin
            wr(power_clock_pkg::OFF_POWER_CONTROL_SECOND, 8'(1 << (i % 2)));
            cyc(3);
            count(16);
            chk8("sleep_core", 8'h00, cnt);
            chk8("sleep_timer", 8'h04, tcnt);
            chk8("sleep_bias", {7'h0, i % 2 == 1}, {7'h0, low_bias});
            cyc(1);
            lu_irq <= 4'h2;
            cyc(5);
            lu_irq <= 4'h0;
            rd(power_clock_pkg::OFF_STATUS, (i % 2) ? 8'h43 : 8'h02, "masked_unit");
            cyc(1);
            wk <= (i < 5) ? 5'(1 << i) : 5'h00;
            lu_irq <= (i == 5) ? 4'h1 : 4'h0;
            cyc(3);
            wk <= 5'h00;
            lu_irq <= 4'h0;
            rd(power_clock_pkg::OFF_STATUS, 8'h16, "wake_status");
            count(150);
            chk8("wake_core_off", 8'h00, cnt);
            wait_core(300);
            rd(power_clock_pkg::OFF_POWER_CONTROL_SECOND, 8'h00, "sleep_cleared");
        end
        done("sleep");
        wr(power_clock_pkg::OFF_REGULATOR_CONTROL, 8'h00);
        wr(power_clock_pkg::OFF_POWER_CONTROL_FIRST, 8'h02);
        cyc(1);
        any_irq <= 1'b1;
        wk <= 5'h01;
        cyc(4);
        any_irq <= 1'b0;
        wk <= 5'h00;
        count(8);
        chk8("stop_pins", 8'h03, {5'h0, por_only, retain, nets_off});
        chk8("stop_core", 8'h00, cnt);
        do_reset();
        rd(power_clock_pkg::OFF_STATUS, 8'h10, "after_stop");
        wr(power_clock_pkg::OFF_REGULATOR_CONTROL, 8'h01);
        wr(power_clock_pkg::OFF_POWER_CONTROL_FIRST, 8'h02);
        count(8);
        chk8("shutdown_pins", 8'h07, {5'h0, por_only, retain, nets_off});
        do_reset();
        rd(power_clock_pkg::OFF_CLOCK_SELECT, 8'h30, "clock_after_reset");
        done("stop");
        tally_and_finish();
    end
endmodule

bind power_mode_clock_control power_mode_clock_control_properties props (
    .clk_sys(clk_sys), .reset_n(reset_n), .low_freq_osc_tick(low_freq_osc_tick),
    .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .timer34_lf_clk_en(timer34_lf_clk_en),
    .hf_osc_24m_enable(hf_osc_24m_enable), .hf_osc_49m_enable(hf_osc_49m_enable),
    .regulator_low_bias(regulator_low_bias), .power_nets_off(power_nets_off),
    .pin_retain(pin_retain), .reset_pin_por_only(reset_pin_por_only)
);

`default_nettype wire
